// [common/ppg_pkg.sv]
package ppg_pkg;

  localparam int PW_W = 16;

  // protection tag / privilege codes
  localparam logic [1:0] LVL_NONE      = 2'h0;
  localparam logic [1:0] LVL_USER      = 2'h1;
  localparam logic [1:0] LVL_INSTALLER = 2'h2;
  localparam logic [1:0] LVL_MAKER     = 2'h3;

  // parameter numbers of the password set
  localparam logic [15:0] PAR_ENTERED  = 16'h0000;
  localparam logic [15:0] PAR_PW_MAKER = 16'h0001;
  localparam logic [15:0] PAR_PW_INST  = 16'h0002;
  localparam logic [15:0] PAR_PW_USER  = 16'h0003;
  localparam logic [15:0] PAR_PW_SER   = 16'h0004;

  localparam logic [15:0] PW_SER_RESET = 16'h007B; // decimal 123
  localparam logic [15:0] PW_ZERO      = 16'h0000;

  // serial holding registers
  localparam logic [15:0] HR_SER_PW  = 16'h0065; // decimal 101
  localparam logic [15:0] HR_SER_CMD = 16'h0066; // decimal 102

  // timing
  localparam longint CLK_HZ        = 250_000_000;
  localparam longint IDLE_TIME_S   = 600;
  localparam longint IDLE_CYCLES   = IDLE_TIME_S * CLK_HZ;
  localparam longint SER_WIN_S     = 5;
  localparam longint SER_WIN_CYCLES = SER_WIN_S * CLK_HZ;

endpackage

// [rtl/ppg_gate.sv]
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ppg_gate
  import ppg_pkg::*;
#(
  parameter longint IDLE_CYC = IDLE_CYCLES,
  parameter longint SER_CYC  = SER_WIN_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        mode_off_reset,
  input  wire logic        prog_active,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [1:0]  par_tag,
  input  wire logic        par_special,
  output logic             par_wr_ok,
  output logic [1:0]       priv_level,
  output logic             code_valid,
  input  wire logic        ser_wr,
  input  wire logic [15:0] ser_addr,
  input  wire logic [15:0] ser_wdata,
  output logic             ser_cmd_valid,
  output logic      [15:0] ser_cmd
);

  ////////////////////////////////////////////////////////////////////////////
  // password store

  logic [15:0] pw_maker_q;
  logic [15:0] pw_inst_q;
  logic [15:0] pw_user_q;
  logic [15:0] pw_ser_q;
  logic [15:0] entered_q;
  logic [1:0]  priv;
  logic        maker_set;
  logic        inst_set;
  logic        user_set;
  logic        hit_maker;
  logic        hit_inst;
  logic        hit_user;
  logic        valid;
  logic        wr_ok_comb;

  // a zero stored value means no password at that level
  assign maker_set = (pw_maker_q != PW_ZERO);
  assign inst_set  = (pw_inst_q  != PW_ZERO);
  assign user_set  = (pw_user_q  != PW_ZERO);

  // exact full-width match, zero never matches
  assign hit_maker = (entered_q != PW_ZERO) && maker_set && (entered_q == pw_maker_q);
  assign hit_inst  = (entered_q != PW_ZERO) && inst_set  && (entered_q == pw_inst_q);
  assign hit_user  = (entered_q != PW_ZERO) && user_set  && (entered_q == pw_user_q);
  assign valid     = hit_maker | hit_inst | hit_user;

  ////////////////////////////////////////////////////////////////////////////
  // effective privilege

  // compare entered code, raise through unprotected upper levels
  always_comb begin
    priv = LVL_NONE;
    if (hit_maker) begin
      priv = LVL_MAKER;
    end else if (hit_inst) begin
      priv = maker_set ? LVL_INSTALLER : LVL_MAKER;
    end else if (hit_user) begin
      if (!inst_set && !maker_set) begin
        priv = LVL_MAKER;
      end else if (!inst_set) begin
        priv = LVL_INSTALLER;
      end else begin
        priv = LVL_USER;
      end
    end else if (!user_set) begin
      // no valid code: free levels up to the first configured password
      if (!inst_set && !maker_set) begin
        priv = LVL_MAKER;
      end else if (!inst_set) begin
        priv = LVL_INSTALLER;
      end else begin
        priv = LVL_USER;
      end
    end else begin
      priv = LVL_NONE;
    end
  end

  // tag against privilege, mode and special lock
  always_comb begin
    wr_ok_comb = 1'b0;
    if (par_tag != LVL_NONE) begin
      unique case (par_tag)
        LVL_MAKER:     wr_ok_comb = (priv == LVL_MAKER);
        LVL_INSTALLER: wr_ok_comb = (priv == LVL_MAKER) || (priv == LVL_INSTALLER);
        LVL_USER:      wr_ok_comb = (priv != LVL_NONE);
        default:       wr_ok_comb = 1'b0;
      endcase
    end
    if (par_special && !hit_maker) begin
      wr_ok_comb = 1'b0;
    end
    if (!mode_off_reset) begin
      wr_ok_comb = 1'b0;
    end
  end

  assign par_wr_ok  = wr_ok_comb;
  assign priv_level = priv;
  assign code_valid = valid;

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  logic write_pw_ok;
  // password writes need an open gate for that rank
  assign write_pw_ok = mode_off_reset && (priv != LVL_NONE);

  // entered code register with idle clear
  logic [63:0] idle_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      entered_q <= PW_ZERO;
      idle_q    <= 64'h0;
    end else if (ce) begin
      if (reg_wr && reg_addr == PAR_ENTERED) begin
        entered_q <= reg_wdata;
        idle_q    <= 64'h0;
      end else if (prog_active) begin
        idle_q <= 64'h0;
      end else if (idle_q >= 64'(IDLE_CYC) - 64'h1) begin
        entered_q <= PW_ZERO;
        idle_q    <= 64'h0;
      end else begin
        idle_q <= idle_q + 64'h1;
      end
    end
  end

  // stored passwords, lower ones writable by higher rank
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pw_maker_q <= PW_ZERO;
      pw_inst_q  <= PW_ZERO;
      pw_user_q  <= PW_ZERO;
      pw_ser_q   <= PW_SER_RESET;
    end else if (ce && reg_wr && write_pw_ok) begin
      unique case (reg_addr)
        PAR_PW_MAKER: if (priv == LVL_MAKER) pw_maker_q <= reg_wdata;
        PAR_PW_INST:  if (priv == LVL_MAKER || priv == LVL_INSTALLER) pw_inst_q <= reg_wdata;
        PAR_PW_USER:  pw_user_q <= reg_wdata;
        PAR_PW_SER:   if (priv == LVL_MAKER) pw_ser_q <= reg_wdata;
        default:      ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, passwords hidden without a valid code

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        unique case (reg_addr)
          PAR_ENTERED:  reg_rdata <= entered_q;
          PAR_PW_MAKER: reg_rdata <= valid ? pw_maker_q : 16'h0000;
          PAR_PW_INST:  reg_rdata <= valid ? pw_inst_q  : 16'h0000;
          PAR_PW_USER:  reg_rdata <= valid ? pw_user_q  : 16'h0000;
          PAR_PW_SER:   reg_rdata <= valid ? pw_ser_q   : 16'h0000;
          default:      reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial command gate

  logic        armed_q;
  logic [63:0] win_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q       <= 1'b0;
      win_q         <= 64'h0;
      ser_cmd_valid <= 1'b0;
      ser_cmd       <= 16'h0000;
    end else if (ce) begin
      ser_cmd_valid <= 1'b0;
      if (armed_q) begin
        win_q <= win_q + 64'h1;
        if (win_q >= 64'(SER_CYC) - 64'h1) begin
          armed_q <= 1'b0;
        end
      end
      if (ser_wr && ser_addr == HR_SER_PW) begin
        armed_q <= (ser_wdata == pw_ser_q);
        win_q   <= 64'h0;
      end else if (ser_wr && ser_addr == HR_SER_CMD) begin
        if (armed_q) begin
          ser_cmd_valid <= 1'b1;
          ser_cmd       <= ser_wdata;
        end
        armed_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [sim/ppg_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ppg_host_model
  import ppg_pkg::*;
(
  input  wire logic        clk,
  output logic             ser_wr,
  output logic [15:0]      ser_addr,
  output logic [15:0]      ser_wdata
);
  initial begin
    ser_wr = 1'b0;
    ser_addr = 16'hFFFF;
    ser_wdata = 16'hFFFF;
  end
  // one holding register write; released lines show the inverse
  task put(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    ser_wr <= 1'b1;
    ser_addr <= a;
    ser_wdata <= d;
    @(posedge clk);
    ser_wr <= 1'b0;
    ser_addr <= ~a;
    ser_wdata <= ~d;
  endtask
  // password first, command after a chosen gap
  task send(input logic [15:0] pw, input logic [15:0] cmd, input int gap);
    put(HR_SER_PW, pw);
    repeat (gap) @(posedge clk);
    put(HR_SER_CMD, cmd);
  endtask
endmodule
`default_nettype wire

// [sim/ppg_gate_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module ppg_gate_asserts
  import ppg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        mode_off_reset,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_rdata,
  input  wire logic [1:0]  par_tag,
  input  wire logic        par_special,
  input  wire logic        par_wr_ok,
  input  wire logic [1:0]  priv_level,
  input  wire logic        code_valid,
  input  wire logic        ser_wr,
  input  wire logic [15:0] ser_addr,
  input  wire logic        ser_cmd_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_wr_needs_mode: assert property (par_wr_ok |-> mode_off_reset)
    else $error("write allowed outside halted mode");
  a_tag_rank: assert property (par_wr_ok |-> par_tag != LVL_NONE && priv_level >= par_tag)
    else $error("write allowed above privilege");
  a_none_blocks: assert property (priv_level == LVL_NONE |-> !par_wr_ok)
    else $error("write allowed with no privilege");
  a_special_hit: assert property (par_wr_ok && par_special |-> code_valid && priv_level == LVL_MAKER)
    else $error("special write without maker code");
  a_code_priv: assert property (code_valid |-> priv_level != LVL_NONE)
    else $error("valid code gave no privilege");
  a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read answer");
  a_pw_hidden: assert property (ce && reg_rd && !code_valid && reg_addr != PAR_ENTERED |=> reg_rdata == 16'h0000)
    else $error("password shown without valid code");
  a_cmd_cause: assert property (!(ce && ser_wr && ser_addr == HR_SER_CMD) |=> !ser_cmd_valid)
    else $error("command without command write");
  a_cmd_pulse: assert property (ser_cmd_valid && ce |=> !ser_cmd_valid)
    else $error("command pulse too long");
endmodule
bind ppg_gate ppg_gate_asserts chk_u (.clk, .rst, .ce, .mode_off_reset, .reg_rd, .reg_addr,
  .reg_rdata, .par_tag, .par_special, .par_wr_ok, .priv_level, .code_valid, .ser_wr, .ser_addr,
  .ser_cmd_valid);
`default_nettype wire

// [sim/tb_ppg_gate.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_ppg_gate;
  import ppg_pkg::*;
  logic clk = 0, rst = 1, ce = 1, mode = 1, prog = 1, wr = 0, rd = 0, spc = 0, ser_wr, cv, ok, vld;
  logic [15:0] addr = 0, wd = 0, rdata, sa, sd, cmd, v;
  logic [1:0]  tag = 0, priv;
  int n_errors = 0, compares = 0;
  localparam longint IDLE = 50, SER = 20;
  ppg_gate #(.IDLE_CYC(IDLE), .SER_CYC(SER)) dut_u (.clk(clk), .rst(rst), .ce(ce),
    .mode_off_reset(mode), .prog_active(prog), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .par_tag(tag), .par_special(spc), .par_wr_ok(ok),
    .priv_level(priv), .code_valid(cv), .ser_wr(ser_wr), .ser_addr(sa), .ser_wdata(sd),
    .ser_cmd_valid(vld), .ser_cmd(cmd));
  ppg_host_model host_u (.clk(clk), .ser_wr(ser_wr), .ser_addr(sa), .ser_wdata(sd));
  initial forever #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wrr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdr(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // write permission for a tag, special flag and mode, plus privilege
  task pchk(input logic [1:0] t, input logic s, input logic m, input logic e, input logic [1:0] p);
    @(posedge clk);
    tag <= t;
    spc <= s;
    mode <= m;
    @(negedge clk);
    chk("wr_ok", 16'(ok), 16'(e));
    chk("priv", 16'(priv), 16'(p));
  endtask
  task cmd_chk(input logic [15:0] pw, input int gap, input logic e);
    host_u.send(pw, 16'h0003, gap);
    @(negedge clk);
    chk("cmd_valid", 16'(vld), 16'(e));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    n_errors++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    pchk(LVL_MAKER, 0, 1, 1, LVL_MAKER);
    pchk(LVL_MAKER, 1, 1, 0, LVL_MAKER);
    pchk(LVL_USER, 0, 0, 0, LVL_MAKER);
    pchk(LVL_NONE, 0, 1, 0, LVL_MAKER);
    rdr(PAR_PW_SER, v); chk("hidden", v, 16'h0000);
    cmd_chk(PW_SER_RESET, 0, 1); chk("cmd", cmd, 16'h0003);
    cmd_chk(16'h007C, 0, 0);
    cmd_chk(PW_SER_RESET, SER + 5, 0);
    wrr(PAR_PW_USER, 16'h0055);
    pchk(LVL_USER, 0, 1, 0, LVL_NONE);
    wrr(PAR_ENTERED, 16'h0055);
    pchk(LVL_MAKER, 0, 1, 1, LVL_MAKER);
    wrr(PAR_PW_MAKER, 16'h00C3);
    pchk(LVL_MAKER, 0, 1, 0, LVL_INSTALLER);
    pchk(LVL_INSTALLER, 0, 1, 1, LVL_INSTALLER);
    pchk(LVL_USER, 0, 1, 1, LVL_INSTALLER);
    wrr(PAR_ENTERED, 16'h00C3);
    pchk(LVL_MAKER, 1, 1, 1, LVL_MAKER);
    rdr(PAR_PW_MAKER, v); chk("pw_maker", v, 16'h00C3);
    rdr(PAR_PW_SER, v); chk("pw_ser", v, PW_SER_RESET);
    wrr(PAR_PW_USER, PW_ZERO);
    wrr(PAR_ENTERED, 16'h00C4);
    @(negedge clk); chk("code_valid", 16'(cv), 16'h0000);
    pchk(LVL_INSTALLER, 0, 1, 1, LVL_INSTALLER);
    // a write while the clock enable is low must leave the entered code alone
    ce <= 1'b0;
    wrr(PAR_ENTERED, 16'h0055);
    ce <= 1'b1;
    rdr(PAR_ENTERED, v);
    chk("ce_freeze", v, 16'h00C4);
    wrr(PAR_ENTERED, 16'h00C3);
    prog <= 1'b0;
    repeat (IDLE + 10) @(posedge clk);
    rdr(PAR_ENTERED, v); chk("entered", v, 16'h0000);
    chk("code_valid", 16'(cv), 16'h0000);
    close_out;
  end
endmodule
`default_nettype wire
